// ===== tcr_pkg.sv
// Purpose: Constants and carriers for the terminal control register bank.
// Assumes: 100 MHz clock, 32-bit classic Wishbone, byte addresses, registers four apart.
// Notes:   Summary of operation
// Summary of operation
// RL1: RT illegal and illegal-broadcast events gated by enables.
// RL2: Poll match needs enable bit and block bit.
// RL3: Retry-fail event gated by its enable bit.
// RL4: Message error event gated in all modes.
// RL5: Interrupt-and-continue event gated in BC and monitor.
// RL6: Register bits drive instrumentation, service, busy status.
// RL7: Busy mode sets busy and blocks transfers.
// RL8: Subsystem flag set; logged in message status.
// RL9: Bus control acceptance answers dynamic mode code.
// RL10: Terminal flag from register bit or self-test failure.
// RL11: Bit 8 reads controller/terminal select pin.
// RL12: Lock-out pin blocks address and mode writes; mode writes still load the mode register, only mode_sel_we_o is held low.
// RL13: Parity error flagged when address parity even.
// RL14: Address loaded from pins at reset, writable.
// RL15: Any self-test write runs 100 us test.
// RL16: Host writes soft reset before self-test start.
// RL17: Channel failures set word bits and fail pin.
// RL18: Terminal ignores bus commands during self-test.
// RL19: Soft reset pulses protocol reset under 1 us.
// RL20: Eight-bit time tag, 64 us tick, clear on write.
// RL21: Monitor active with bit 15 and mode bit zero.
// RL22: Host sets one monitor scope bit in monitor.
// RL23: Enabled standard interrupt sets status, drives irq low.
// RL24: Reserved bits read zero; triggers leave state alone.
`default_nettype none
package tcr_pkg;
  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [7:0] ADR_EVT_EN  = 8'h24;
  localparam logic [7:0] ADR_TADDR   = 8'h28;
  localparam logic [7:0] ADR_ST_GO   = 8'h2c;
  localparam logic [7:0] ADR_SRST    = 8'h30;
  localparam logic [7:0] ADR_TT_CLR  = 8'h34;
  localparam logic [7:0] ADR_MODE    = 8'h38;
  localparam logic [7:0] ADR_STATUS  = 8'h3c;
  localparam logic [7:0] ADR_ST_WORD = 8'h40;
  localparam logic [7:0] ADR_TTAG    = 8'h44;
  localparam logic [15:0] EVT_EN_MASK = 16'h003f;
  localparam logic [15:0] TADDR_WMASK = 16'hfe3f;
  localparam logic [15:0] MODE_WMASK  = 16'he000;
  localparam logic [15:0] RST_ZERO    = 16'h0000;
  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int EV_ILL_BC = 5;
  localparam int EV_ILL    = 4;
  localparam int EV_POLL   = 3;
  localparam int EV_RETRY  = 2;
  localparam int EV_MSGERR = 1;
  localparam int EV_IAC    = 0;
  localparam int TA_INSTR  = 15;
  localparam int TA_BUSY   = 14;
  localparam int TA_SSF    = 13;
  localparam int TA_DBCA   = 12;
  localparam int TA_TFLAG  = 11;
  localparam int TA_SRQ    = 10;
  localparam int TA_BUSYM  = 9;
  localparam int TA_SEL    = 8;
  localparam int TA_LOCK   = 7;
  localparam int TA_PERR   = 6;
  localparam int TA_PAR    = 5;
  localparam int MD_MON    = 15;
  localparam int MD_ALL    = 14;
  localparam int MD_DECL   = 13;
  localparam int ST_CHA    = 14;
  localparam int ST_CHB    = 15;
  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int CLK_MHZ     = 100;
  localparam int ST_TIME_US  = 100;
  localparam int SRST_TIME_NS = 1000;
  localparam int TICK_US     = 64;
  localparam int ST_CYC      = ST_TIME_US * CLK_MHZ;
  localparam int SRST_CYC    = (SRST_TIME_NS * CLK_MHZ) / 1000 - 1;
  localparam int TICK_CYC    = TICK_US * CLK_MHZ;
  localparam logic [6:0] SRST_LEN = 7'(SRST_CYC);
  // -----------------------------------------------------------------
  // Carriers
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN} tcr_st_t;
  typedef struct packed {
    logic ill_bcast;
    logic ill_cmd;
    logic poll_match;
    logic poll_blk_en;
    logic retry_fail;
    logic msg_err;
    logic iac_done;
    logic dbc_code;
  } tcr_evt_t;
  typedef struct packed {
    logic instr;
    logic busy;
    logic ssf;
    logic dbca;
    logic tflag;
    logic srq;
  } tcr_sw_t;
endpackage
`default_nettype wire

// ===== tcr_regs.sv
// Purpose: Terminal control register bank on classic Wishbone.
// Assumes: Inputs synchronous to clk_i; self-test result from the codec.
// Notes:   Ack comes one cycle after the request is seen.
//
// Our own choices: the register addresses and register access over Wishbone.
`default_nettype none
module tcr_regs
  import tcr_pkg::*;
#(
  parameter int ST_CYCLES   = ST_CYC,
  parameter int TICK_CYCLES = TICK_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [4:0]  terminal_address_pins_i,
  input  wire logic        address_parity_pin_i,
  input  wire logic        controller_terminal_select_pin_i,
  input  wire logic        change_lockout_pin_i,
  input  wire logic        ctrl_mode_bc_i,
  input  wire logic        rt_mode_i,
  input  wire tcr_evt_t    evt_i,
  input  wire logic        st_done_i,
  input  wire logic        st_fail_a_i,
  input  wire logic        st_fail_b_i,
  input  wire logic        std_irq_clr_i,
  output logic             mode_sel_we_o,
  output logic             standard_irq_n_o,
  output logic             std_irq_status_o,
  output logic             self_test_fail_pin_o,
  output logic             self_test_busy_o,
  output logic             proto_reset_o,
  output logic             cmd_ignore_o,
  output logic             xfer_inhibit_o,
  output logic             msg_ssf_log_o,
  output tcr_sw_t          status_bits_o,
  output logic             monitor_active_o,
  output logic             monitor_all_o,
  output logic             monitor_declared_o,
  output logic [4:0]       term_addr_o,
  output logic [7:0]       time_tag_o
);
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] evt_en;
    logic [15:0] taddr;
    logic [15:0] mode;
    logic [1:0]  st_word;
    tcr_st_t     st;
    logic [13:0] st_cnt;
    logic [6:0]  srst_cnt;
    logic        srst;
    logic [12:0] tick_cnt;
    logic [7:0]  ttag;
    logic        irq;
    logic        ack;
    logic [31:0] rdat;
    logic        init;
    logic        mode_we;
  } tcr_state_t;

  tcr_state_t r;
  tcr_state_t next_r;
  logic       req;
  logic       wr;
  logic       hit;
  logic       std_evt;
  logic       rt_mon;
  logic [15:0] rd;

  assign req = wb_cyc_i && wb_stb_i && !r.ack;
  assign wr  = req && wb_we_i && wb_sel_i[0];

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    rt_mon = !ctrl_mode_bc_i;
    std_evt =
      (rt_mode_i && r.evt_en[EV_ILL_BC] && evt_i.ill_bcast) || // RL1
      (rt_mode_i && r.evt_en[EV_ILL] && evt_i.ill_cmd) || // RL1
      (ctrl_mode_bc_i && r.evt_en[EV_POLL] && evt_i.poll_match &&
       evt_i.poll_blk_en) || // RL2
      (ctrl_mode_bc_i && r.evt_en[EV_RETRY] && evt_i.retry_fail) || // RL3
      (r.evt_en[EV_MSGERR] && evt_i.msg_err) || // RL4
      ((ctrl_mode_bc_i || (rt_mon && r.mode[MD_MON])) &&
       r.evt_en[EV_IAC] && evt_i.iac_done); // RL5
    // Set wins over the clear so no event is dropped.
    if (std_evt)
      next_r.irq = 1'b1; // RL23
    else if (std_irq_clr_i)
      next_r.irq = 1'b0;
    rd = RST_ZERO;
    hit = 1'b1;
    case (wb_adr_i)
      ADR_EVT_EN:  rd = r.evt_en & EVT_EN_MASK; // RL24
      ADR_TADDR:   rd = r.taddr;
      ADR_MODE:    rd = r.mode;
      ADR_STATUS:  rd = {15'h0000, r.st == ST_RUN};
      ADR_ST_WORD: rd = {r.st_word, 14'h0000};
      ADR_TTAG:    rd = {8'h00, r.ttag};
      ADR_ST_GO, ADR_SRST, ADR_TT_CLR: rd = RST_ZERO; // RL24
      default:     hit = 1'b0;
    endcase
    next_r.ack  = req;
    next_r.rdat = (hit && !wb_we_i) ? {16'h0000, rd} : 32'h00000000;
    next_r.mode_we = 1'b0;
    if (wr)
    begin
      case (wb_adr_i)
        ADR_EVT_EN: next_r.evt_en = wb_dat_i[15:0] & EVT_EN_MASK; // RL24
        ADR_TADDR:
        begin
          next_r.taddr[15:9] = wb_dat_i[15:9]; // RL6
          if (!change_lockout_pin_i)
            next_r.taddr[5:0] = wb_dat_i[5:0]; // RL14
          next_r.init = 1'b1; // RL12
        end
        ADR_MODE:
        begin
          next_r.mode = wb_dat_i[15:0] & MODE_WMASK; // RL21
          next_r.mode_we = !change_lockout_pin_i; // RL12
        end
        ADR_ST_GO:
        begin
          next_r.st = ST_RUN; // RL15
          next_r.st_cnt = '0;
          next_r.st_word = 2'b00;
        end
        ADR_SRST:
        begin
          next_r.srst = 1'b1; // RL19
          next_r.srst_cnt = '0;
        end
        ADR_TT_CLR:
        begin
          next_r.ttag = 8'h00; // RL20
          next_r.tick_cnt = '0;
        end
        default: ;
      endcase
    end
    // Address pins are caught on the first clock after reset release.
    if (!r.init)
    begin
      next_r.taddr[4:0]    = terminal_address_pins_i; // RL14
      next_r.taddr[TA_PAR] = address_parity_pin_i;
      next_r.init          = 1'b1;
    end
    next_r.taddr[TA_PERR] = ~^next_r.taddr[5:0]; // RL13
    next_r.taddr[TA_SEL]  = controller_terminal_select_pin_i; // RL11
    next_r.taddr[TA_LOCK] = change_lockout_pin_i; // RL12
    case (r.st)
      ST_RUN:
      begin
        if (!(wr && wb_adr_i == ADR_ST_GO))
          next_r.st_cnt = r.st_cnt + 14'h0001;
        if (st_fail_a_i)
          next_r.st_word[0] = 1'b1; // RL17
        if (st_fail_b_i)
          next_r.st_word[1] = 1'b1; // RL17
        if (st_done_i || r.st_cnt == 14'(ST_CYCLES - 1))
          next_r.st = ST_IDLE; // RL15
      end
      ST_IDLE: ;
      default: next_r.st = ST_IDLE;
    endcase
    if (r.srst && !(wr && wb_adr_i == ADR_SRST))
    begin
      next_r.srst_cnt = r.srst_cnt + 7'h01;
      if (r.srst_cnt == SRST_LEN - 7'h01)
        next_r.srst = 1'b0; // RL19
    end
    if (!(wr && wb_adr_i == ADR_TT_CLR))
    begin
      if (r.tick_cnt == 13'(TICK_CYCLES - 1))
      begin
        next_r.tick_cnt = '0;
        next_r.ttag = r.ttag + 8'h01; // RL20
      end
      else
        next_r.tick_cnt = r.tick_cnt + 13'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.st <= ST_IDLE;
    end
    else
      r <= next_r;
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  logic [1:0]  fail_q;
  tcr_sw_t     sw_q;
  logic [10:0] misc_q;
  logic [7:0]  tt_q;
  logic [4:0]  ta_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fail_q <= 2'b00;
      sw_q   <= '0;
      misc_q <= '0;
      tt_q   <= 8'h00;
      ta_q   <= 5'h00;
    end
    else
    begin
      fail_q <= {|next_r.st_word, 1'b0}; // RL17
      sw_q.instr <= next_r.taddr[TA_INSTR]; // RL6
      sw_q.busy  <= next_r.taddr[TA_BUSY] || next_r.taddr[TA_BUSYM]; // RL7
      sw_q.ssf   <= next_r.taddr[TA_SSF]; // RL8
      sw_q.dbca  <= next_r.taddr[TA_DBCA] && evt_i.dbc_code; // RL9
      sw_q.tflag <= next_r.taddr[TA_TFLAG] || |next_r.st_word; // RL10
      sw_q.srq   <= next_r.taddr[TA_SRQ]; // RL6
      misc_q[0] <= next_r.st == ST_RUN;
      misc_q[1] <= next_r.srst; // RL19
      misc_q[2] <= rt_mode_i && next_r.st == ST_RUN; // RL18
      misc_q[3] <= next_r.taddr[TA_BUSYM]; // RL7
      misc_q[4] <= rt_mode_i && next_r.taddr[TA_SSF]; // RL8
      misc_q[5] <= next_r.mode[MD_MON] && !ctrl_mode_bc_i; // RL21
      misc_q[6] <= next_r.mode[MD_ALL]; // RL22
      misc_q[7] <= next_r.mode[MD_DECL]; // RL22
      misc_q[8] <= next_r.irq; // RL23
      misc_q[9] <= next_r.mode_we;
      misc_q[10] <= 1'b0;
      tt_q <= next_r.ttag;
      ta_q <= next_r.taddr[4:0];
    end
  end

  assign wb_dat_o             = r.rdat;
  assign wb_ack_o             = r.ack;
  assign self_test_fail_pin_o = fail_q[1];
  assign status_bits_o        = sw_q;
  assign self_test_busy_o     = misc_q[0];
  assign proto_reset_o        = misc_q[1];
  assign cmd_ignore_o         = misc_q[2];
  assign xfer_inhibit_o       = misc_q[3];
  assign msg_ssf_log_o        = misc_q[4];
  assign monitor_active_o     = misc_q[5];
  assign monitor_all_o        = misc_q[6];
  assign monitor_declared_o   = misc_q[7];
  assign std_irq_status_o     = misc_q[8];
  assign standard_irq_n_o     = !misc_q[8];
  assign mode_sel_we_o        = misc_q[9];
  assign time_tag_o           = tt_q;
  assign term_addr_o          = ta_q;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  sequence s_go;
    wr && wb_adr_i == ADR_ST_GO;
  endsequence
  property p_st_busy;
    @(posedge clk_i) disable iff (rst_i)
    s_go |-> ##2 self_test_busy_o;
  endproperty
  a_st_busy: assert property (p_st_busy) // RL15
    else $error("self-test busy not raised");
  property p_srst;
    @(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADR_SRST) |-> ##1 proto_reset_o;
  endproperty
  a_srst: assert property (p_srst) // RL19
    else $error("soft reset not raised");
  property p_srst_len;
    @(posedge clk_i) disable iff (rst_i)
    $rose(proto_reset_o) |-> ##[1:100] !proto_reset_o;
  endproperty
  a_srst_len: assert property (p_srst_len) // RL19
    else $error("soft reset too long");
  property p_ttclr;
    @(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADR_TT_CLR) |-> ##2 time_tag_o == 8'h00;
  endproperty
  a_ttclr: assert property (p_ttclr) // RL20
    else $error("time tag not cleared");
  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    (evt_i.msg_err && r.evt_en[EV_MSGERR]) |-> ##2 !standard_irq_n_o;
  endproperty
  a_irq: assert property (p_irq) // RL4
    else $error("message error irq missing");
  property p_lock;
    @(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADR_TADDR && change_lockout_pin_i && r.init)
      |=> $stable(r.taddr[4:0]);
  endproperty
  a_lock: assert property (p_lock) // RL12
    else $error("address changed under lock-out");
  property p_perr;
    @(posedge clk_i) disable iff (rst_i)
    r.init |-> r.taddr[TA_PERR] == ~^r.taddr[5:0];
  endproperty
  a_perr: assert property (p_perr) // RL13
    else $error("parity error flag wrong");
  property p_rsvd;
    @(posedge clk_i) disable iff (rst_i)
    r.evt_en[15:6] == 10'h000;
  endproperty
  a_rsvd: assert property (p_rsvd) // RL24
    else $error("reserved enable bits set");
  property p_mode_we;
    @(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADR_MODE)
      |=> mode_sel_we_o == !$past(change_lockout_pin_i);
  endproperty
  a_mode_we: assert property (p_mode_we) // RL12
    else $error("mode select write permission wrong");
endmodule
`default_nettype wire

// ===== tcr_host_model.sv
// Purpose: Host processor model issuing classic Wishbone cycles.
// Assumes: The bank answers each request with a registered ack.
// Notes:   A wait that runs out returns ok low to the caller.
`default_nettype none
module tcr_host_model
  import tcr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic      [7:0]  wb_adr_o,
  output logic      [3:0]  wb_sel_o,
  output logic      [31:0] wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'hff;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'hffffffff;
  end
  // Request is held until ack is seen or the wait runs out; released lines show inverted data
  // so that a stale value can never be read as a fresh one.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic ok);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hf;
    wb_dat_o <= {16'h0000, d};
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    ok = (wb_ack_i === 1'b1);
    q = wb_dat_i[15:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    wb_adr_o <= ~a;
    wb_dat_o <= ~{16'h0000, d};
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the terminal control register bank.
// Assumes: Shortened self-test and tick counts; host model on the bus.
// Notes:   Every wait is bounded; one that runs out fails the run.
`default_nettype none
module tb_top
  import tcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STC = 50;
  localparam int TKC = 16;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dw, wb_dr;
  logic        par = 1'b0, sel_pin = 1'b1, lock = 1'b0;
  logic        bc = 1'b0, rt = 1'b1, st_fa = 1'b0, st_fb = 1'b0;
  logic        clr = 1'b0;
  tcr_evt_t    evt = '0;
  logic        mode_we, irq_n, irq_sta, fail_pin, st_busy, prst;
  logic        cmd_ign, xinh, ssf_log, mon_act, mon_all, mon_decl;
  tcr_sw_t     sw;
  logic [4:0]  taddr;
  logic [7:0]  ttag;
  logic [15:0] q;
  int          fails = 0;
  int          comparisons = 0;
  int          n;
  int          eb[6] = '{1, 2, 3, 5, 6, 7};

  always #5 clk_i = ~clk_i;

  tcr_host_model host (.clk_i(clk_i), .wb_ack_i(wb_ack), .wb_dat_i(wb_dr),
    .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dw));

  tcr_regs #(.ST_CYCLES(STC), .TICK_CYCLES(TKC)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dw),
    .wb_dat_o(wb_dr), .wb_ack_o(wb_ack),
    .terminal_address_pins_i(5'h0a), .address_parity_pin_i(par),
    .controller_terminal_select_pin_i(sel_pin),
    .change_lockout_pin_i(lock), .ctrl_mode_bc_i(bc), .rt_mode_i(rt),
    .evt_i(evt), .st_done_i(1'b0), .st_fail_a_i(st_fa),
    .st_fail_b_i(st_fb), .std_irq_clr_i(clr), .mode_sel_we_o(mode_we),
    .standard_irq_n_o(irq_n), .std_irq_status_o(irq_sta),
    .self_test_fail_pin_o(fail_pin), .self_test_busy_o(st_busy),
    .proto_reset_o(prst), .cmd_ignore_o(cmd_ign),
    .xfer_inhibit_o(xinh), .msg_ssf_log_o(ssf_log),
    .status_bits_o(sw), .monitor_active_o(mon_act),
    .monitor_all_o(mon_all), .monitor_declared_o(mon_decl),
    .term_addr_o(taddr), .time_tag_o(ttag));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    logic ok;
    host.xfer(w, a, d, q, ok);
    if (!ok)
    begin
      fails++;
      end_sim();
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk(nm, q, exp);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_i);
    evt <= v;
    @(posedge clk_i);
    evt <= '0;
    tick(4);
  endtask
  // Counts high cycles of the reset pulse (0) or the self-test busy (1).
  task automatic cnt_hi(input int which, input int lim, output int c);
    c = 0;
    for (int k = 0; k < lim; k++)
    begin
      tick(1);
      if ((which == 1 ? st_busy : prst) === 1'b1)
        c++;
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(3);
    chk("addr_out", 16'(taddr), 16'h000a);
    chk("irq_n_idle", 16'(irq_n), 16'h0001);
    rchk("addr_reg", ADR_TADDR, 16'h014a);
    rchk("unmapped", 8'h80, 16'h0000);
    acc(1'b1, ADR_EVT_EN, 16'hffff);
    rchk("evt_en", ADR_EVT_EN, 16'h003f);
    $display("test reset_and_map done");
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_i);
      bc <= (i < 4);
      rt <= (i >= 4);
      acc(1'b1, ADR_EVT_EN, 16'h0001 << i);
      pulse((8'hee & ~(8'h01 << eb[i])) | 8'h10);
      chk("irq_n_masked", 16'(irq_n), 16'h0001);
      pulse((8'h01 << eb[i]) | 8'h10);
      chk("irq_n_set", 16'(irq_n), 16'h0000);
      chk("irq_status", 16'(irq_sta), 16'h0001);
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      tick(4);
      chk("irq_n_clr", 16'(irq_n), 16'h0001);
    end
    @(posedge clk_i);
    bc <= 1'b1;
    rt <= 1'b0;
    acc(1'b1, ADR_EVT_EN, 16'h0008);
    pulse(8'h20);
    chk("poll_no_blk", 16'(irq_n), 16'h0001);
    $display("test events done");
    @(posedge clk_i);
    evt <= 8'h01;
    bc <= 1'b0;
    rt <= 1'b1;
    acc(1'b1, ADR_TADDR, 16'hfc2a);
    tick(3);
    rchk("flags_reg", ADR_TADDR, 16'hfd2a);
    chk("sw_all", 16'(sw), 16'h003f);
    chk("no_inhibit", 16'(xinh), 16'h0000);
    chk("ssf_log", 16'(ssf_log), 16'h0001);
    acc(1'b1, ADR_TADDR, 16'h022a);
    tick(3);
    chk("sw_busy", 16'(sw), 16'h0010);
    chk("inhibit", 16'(xinh), 16'h0001);
    @(posedge clk_i);
    evt <= '0;
    lock <= 1'b1;
    acc(1'b1, ADR_TADDR, 16'h0023);
    tick(3);
    chk("locked_addr", 16'(taddr), 16'h000a);
    rchk("locked_reg", ADR_TADDR, 16'h01aa);
    @(posedge clk_i);
    lock <= 1'b0;
    bc <= 1'b0;
    $display("test flags done");
    acc(1'b1, ADR_MODE, 16'hdfff);
    tick(3);
    rchk("mode_reg", ADR_MODE, 16'hc000);
    chk("mon_on", 16'({mon_act, mon_all, mon_decl}), 16'h0006);
    acc(1'b1, ADR_MODE, 16'ha000);
    tick(3);
    chk("mon_decl", 16'({mon_act, mon_all, mon_decl}), 16'h0005);
    @(posedge clk_i);
    bc <= 1'b1;
    tick(3);
    chk("mon_bc", 16'(mon_act), 16'h0000);
    acc(1'b1, ADR_MODE, 16'h0000);
    $display("test monitor done");
    acc(1'b1, ADR_TT_CLR, 16'h1234);
    tick(2);
    chk("tag_clear", 16'(ttag), 16'h0000);
    tick(2 * TKC + TKC / 2);
    chk("tag_run", 16'(ttag), 16'h0002);
    rchk("evt_kept", ADR_EVT_EN, 16'h0008);
    $display("test time_tag done");
    @(posedge clk_i);
    rt <= 1'b1;
    bc <= 1'b0;
    acc(1'b1, ADR_SRST, 16'h0000);
    cnt_hi(0, 150, n);
    chk("srst_len", 16'(n > 0 && n < 100), 16'h0001);
    rchk("regs_kept", ADR_EVT_EN, 16'h0008);
    acc(1'b1, ADR_ST_GO, 16'h5a5a);
    fork
      cnt_hi(1, 200, n);
      begin
        tick(3);
        chk("cmd_ignore", 16'(cmd_ign), 16'h0001);
        rchk("st_running", ADR_STATUS, 16'h0001);
        @(posedge clk_i);
        st_fa <= 1'b1;
        st_fb <= 1'b1;
        @(posedge clk_i);
        st_fa <= 1'b0;
        st_fb <= 1'b0;
      end
    join
    chk("st_len", 16'(n >= STC - 3 && n <= STC + 3), 16'h0001);
    chk("cmd_resume", 16'(cmd_ign), 16'h0000);
    rchk("st_word", ADR_ST_WORD, 16'hc000);
    chk("fail_pin", 16'(fail_pin), 16'h0001);
    chk("tflag_fail", 16'(sw.tflag), 16'h0001);
    $display("test self_test done");
    end_sim();
  end
endmodule
`default_nettype wire
